// ---- rtl/eipl_pkg.sv ----
// Constants shared by the external interrupt pin latch block.
package eipl_pkg;
    // ********************************************
    // Register map
    // ********************************************
    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  ISC_INDEX  = 8'h1A;
    localparam logic [7:0]  BRK_INDEX  = 8'h1B;
    localparam logic [7:0]  ISC_ADDR   = 8'h68;
    localparam logic [7:0]  BRK_ADDR   = 8'h6C;
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    // ********************************************
    // Field positions and reset values
    // ********************************************
    localparam int          PEND_BIT   = 3;
    localparam int          ACK_BIT    = 2;
    localparam int          BLOCK_BIT  = 1;
    localparam int          MODE_BIT   = 0;
    localparam int          BREAK_CLEAR_BIT = 0;
    localparam logic        BLOCK_RST  = 1'h0;
    localparam logic        MODE_RST   = 1'h0;
    localparam logic        BREAK_CLEAR_RST = 1'h0;
    localparam logic        LATCH_RST  = 1'h0;
    localparam logic        PIN_IDLE   = 1'h1;
    // ********************************************
    // Bus answers and vector
    // ********************************************
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [15:0] VECTOR_ADDR = 16'hFFFA;
    localparam logic [31:0] ZERO_WORD   = 32'h0;
    // Mode encoding for the sensitivity select bit.
    typedef enum logic {
        EIPL_EDGE_ONLY,
        EIPL_EDGE_LEVEL
    } eipl_mode_type;
endpackage

// ---- rtl/eipl_pin_sync.sv ----
// Three-stage synchroniser and falling-edge detector for the interrupt pin.
`timescale 1ns/1ns
`default_nettype none
module eipl_pin_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Pin side
    input  wire logic pin_async,
    // Filtered outputs
    output var  logic level_reg,
    output var  logic fall_reg
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic agree;
    logic level_next;

    // A change is accepted only when the second and third stages agree.
    assign agree      = (s2_reg == s3_reg);
    assign level_next = agree ? s3_reg : level_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg    <= eipl_pkg::PIN_IDLE;
            s2_reg    <= eipl_pkg::PIN_IDLE;
            s3_reg    <= eipl_pkg::PIN_IDLE;
            level_reg <= eipl_pkg::PIN_IDLE;
            fall_reg  <= 1'h0;
        end else begin
            s1_reg    <= pin_async;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
            fall_reg  <= level_reg & ~level_next;
        end
    end
endmodule // eipl_pin_sync
`default_nettype wire

// ---- rtl/eipl_top.sv ----
// External interrupt pin latch with its AXI4-Lite status/control and break control registers.
// Contract
// - Falling edge, or low in level mode, sets latch.
// - Fetch, software ack or reset clear latch.
// - Vector fetch acknowledges and clears this latch.
// - Level mode clears after ack and pin high.
// - Level mode: latch held while pin low.
// - Reset clears latch and sensitivity select.
// - Edge mode: acknowledge clears latch at once.
// - Ack bit write-one clears, reads zero.
// - Falling edge after ack latches again.
// - Unblocked request fetches vector at top.
// - Block bit read/write, resets clear, blocks requests.
// - Pending flag shows latch, ignores block bit.
// - Sensitivity bit: one edge-plus-level, zero edge.
// - Break, clear disabled: ack leaves latch alone.
// - Break, clear enabled: ack clears, stays cleared.
// - Register layout: pend, ack, block, mode bits.
// - CPU global mask also blocks the request.
`timescale 1ns/1ns
`default_nettype none
module eipl_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    // AXI4-Lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    // AXI4-Lite write response
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // AXI4-Lite read address
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    // AXI4-Lite read data
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // Interrupt pin, active low
    input  wire logic        ext_irq_n,
    // CPU side
    input  wire logic        vector_fetch,
    input  wire logic        cpu_int_mask,
    input  wire logic        break_state,
    output var  logic        irq_request,
    output var  logic [15:0] vector_address
);
    // ********************************************
    // Address decode functions
    // ********************************************
    function automatic logic is_isc(input logic [31:0] a);
        is_isc = (a[eipl_pkg::ADDR_W-1:0] == eipl_pkg::ISC_ADDR);
    endfunction

    function automatic logic is_brk(input logic [31:0] a);
        is_brk = (a[eipl_pkg::ADDR_W-1:0] == eipl_pkg::BRK_ADDR);
    endfunction

    // ********************************************
    // Declarations
    // ********************************************
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [31:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        latch_reg;
    logic        ack_pend_reg;
    logic        block_reg;
    logic        break_clear_enable_reg;
    logic        irq_request_reg;
    logic [15:0] vector_address_reg;
    eipl_pkg::eipl_mode_type mode_reg;
    logic        pin_level;
    logic        pin_fall;

    // ********************************************
    // Pin synchroniser
    // ********************************************
    eipl_pin_sync u_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_async (ext_irq_n),
        .level_reg (pin_level),
        .fall_reg  (pin_fall)
    );

    // ********************************************
    // Write channel decode
    // ********************************************
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic aw_hold_next;
    logic w_hold_next;
    logic bvalid_next;
    logic wr_isc;
    logic wr_brk;
    logic wr_lane0;
    logic sw_ack;

    assign aw_take      = awvalid & awready_reg;
    assign w_take       = wvalid & wready_reg;
    // Both halves held and no response still waiting.
    assign wr_fire      = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign aw_hold_next = wr_fire ? 1'h0 : (aw_hold_reg | aw_take);
    assign w_hold_next  = wr_fire ? 1'h0 : (w_hold_reg | w_take);
    assign bvalid_next  = wr_fire | (bvalid_reg & ~bready);
    assign wr_isc       = wr_fire & is_isc(aw_addr_reg);
    assign wr_brk       = wr_fire & is_brk(aw_addr_reg);
    assign wr_lane0     = w_strb_reg[0];
    assign sw_ack       = wr_isc & wr_lane0 & w_data_reg[eipl_pkg::ACK_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'h0;
            w_hold_reg  <= 1'h0;
            awready_reg <= 1'h0;
            wready_reg  <= 1'h0;
            bvalid_reg  <= 1'h0;
            bresp_reg   <= eipl_pkg::RESP_OKAY;
            aw_addr_reg <= eipl_pkg::ZERO_WORD;
            w_data_reg  <= eipl_pkg::ZERO_WORD;
            w_strb_reg  <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            awready_reg <= ~aw_hold_next;
            wready_reg  <= ~w_hold_next;
            bvalid_reg  <= bvalid_next;
            if (aw_take) begin
                aw_addr_reg <= awaddr;
            end
            if (w_take) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_fire) begin
                bresp_reg <= (wr_isc | wr_brk) ? eipl_pkg::RESP_OKAY
                                                : eipl_pkg::RESP_SLVERR;
            end
        end
    end

    // ********************************************
    // Read channel
    // ********************************************
    logic        ar_take;
    logic        rvalid_next;
    logic [31:0] isc_word;
    logic [31:0] brk_word;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign ar_take     = arvalid & arready_reg;
    assign rvalid_next = ar_take | (rvalid_reg & ~rready);
    // pending, ack, block, mode; upper bits zero
    // pending flag is the latch, unaffected by block
    assign isc_word = {28'h0, latch_reg, 1'h0, block_reg, mode_reg};
    assign brk_word = {31'h0, break_clear_enable_reg};
    assign rd_hit   = is_isc(araddr) | is_brk(araddr);
    assign rd_word  = is_isc(araddr) ? isc_word
                    : (is_brk(araddr) ? brk_word : eipl_pkg::ZERO_WORD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'h0;
            rvalid_reg  <= 1'h0;
            rdata_reg   <= eipl_pkg::ZERO_WORD;
            rresp_reg   <= eipl_pkg::RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? eipl_pkg::RESP_OKAY : eipl_pkg::RESP_SLVERR;
            end
        end
    end

    // ********************************************
    // Control bits
    // ********************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg  <= eipl_pkg::EIPL_EDGE_ONLY;
            block_reg <= eipl_pkg::BLOCK_RST;
            break_clear_enable_reg <= eipl_pkg::BREAK_CLEAR_RST;
        end else begin
            if (wr_isc & wr_lane0) begin
                mode_reg  <= eipl_pkg::eipl_mode_type'(w_data_reg[eipl_pkg::MODE_BIT]);
                block_reg <= w_data_reg[eipl_pkg::BLOCK_BIT];
            end
            if (wr_brk & wr_lane0) begin
                break_clear_enable_reg <= w_data_reg[eipl_pkg::BREAK_CLEAR_BIT];
            end
        end
    end

    // ********************************************
    // Request latch
    // ********************************************
    logic level_mode;
    logic sw_ack_ok;
    logic ack_eff;
    logic set_cond;
    logic clr_cond;
    logic latch_next;
    logic ack_pend_next;

    assign level_mode = (mode_reg == eipl_pkg::EIPL_EDGE_LEVEL);
    // software ack ignored in break unless enabled
    // with clear enabled, ack acts in break too
    assign sw_ack_ok  = sw_ack & (~break_state | break_clear_enable_reg);
    assign ack_eff    = vector_fetch | sw_ack_ok;
    // edge always, low level in level mode
    // level mode keeps setting while low
    // a new edge sets after any ack
    assign set_cond   = pin_fall | (level_mode & ~pin_level);
    // edge mode clears on ack at once
    // level mode waits for ack and pin high
    assign clr_cond   = level_mode ? ((ack_eff | ack_pend_reg) & pin_level) : ack_eff;
    // set wins over a clear in the same cycle
    assign latch_next = set_cond ? 1'h1 : (clr_cond ? 1'h0 : latch_reg);
    // Remember an ack taken while the pin is still low; a new edge needs a new ack.
    assign ack_pend_next = (~level_mode | pin_fall | ~latch_next) ? 1'h0
                         : (ack_pend_reg | ack_eff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // reset clears the latch even if pin is low
            latch_reg    <= eipl_pkg::LATCH_RST;
            ack_pend_reg <= 1'h0;
        end else begin
            latch_reg    <= latch_next;
            ack_pend_reg <= ack_pend_next;
        end
    end

    // ********************************************
    // Request to priority logic
    // ********************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request_reg    <= 1'h0;
            vector_address_reg <= eipl_pkg::VECTOR_ADDR;
        end else begin
            irq_request_reg    <= latch_reg & ~block_reg & ~cpu_int_mask;
            vector_address_reg <= eipl_pkg::VECTOR_ADDR;
        end
    end

    assign awready        = awready_reg;
    assign wready         = wready_reg;
    assign bvalid         = bvalid_reg;
    assign bresp          = bresp_reg;
    assign arready        = arready_reg;
    assign rvalid         = rvalid_reg;
    assign rdata          = rdata_reg;
    assign rresp          = rresp_reg;
    assign irq_request    = irq_request_reg;
    assign vector_address = vector_address_reg;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_sets;
        pin_fall |=> latch_reg;
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("falling edge did not set latch");
    property p_level_hold;
        level_mode && !pin_level |=> latch_reg;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("latch dropped while pin low in level mode");

    property p_edge_clear;
        !level_mode && latch_reg && ack_eff && !pin_fall |=> !latch_reg;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("edge mode ack did not clear latch");

    property p_level_wait;
        level_mode && latch_reg && ack_eff && !pin_level
            ##1 !$rose(pin_level) && level_mode |=> latch_reg;
    endproperty
    a_level_wait: assert property (p_level_wait)
        else $error("level latch cleared before pin returned high");

    property p_level_clear;
        level_mode && ack_pend_reg && pin_level |=> !latch_reg || pin_fall;
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("level latch not cleared after ack and pin high");
    property p_break_guard;
        latch_reg && break_state && !break_clear_enable_reg && sw_ack && !vector_fetch
            && !ack_pend_reg |=> latch_reg;
    endproperty
    a_break_guard: assert property (p_break_guard)
        else $error("ack in protected break changed latch");
    property p_break_clear;
        !level_mode && break_state && break_clear_enable_reg && sw_ack && !pin_fall
            |=> !latch_reg;
    endproperty
    a_break_clear: assert property (p_break_clear)
        else $error("ack in enabled break did not clear latch");

    property p_req_gate;
        irq_request |-> $past(latch_reg) && !$past(block_reg) && !$past(cpu_int_mask);
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("request not equal to gated latch");

    property p_req_pass;
        latch_reg && !block_reg && !cpu_int_mask |=> irq_request;
    endproperty
    a_req_pass: assert property (p_req_pass)
        else $error("unblocked latch not presented");
    property p_pend_read;
        ar_take && is_isc(araddr) |=> rvalid && rdata[eipl_pkg::PEND_BIT] == $past(latch_reg)
            && !rdata[eipl_pkg::ACK_BIT];
    endproperty
    a_pend_read: assert property (p_pend_read)
        else $error("pending flag read wrong");
    property p_write_resp;
        aw_hold_reg && w_hold_reg && !bvalid_reg |=> bvalid
            && bresp == ($past(wr_isc || wr_brk) ? eipl_pkg::RESP_OKAY : eipl_pkg::RESP_SLVERR);
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write not answered next cycle");

    c_edge_irq: cover property (pin_fall ##1 latch_reg ##1 irq_request);
    c_level_clear: cover property (level_mode && ack_pend_reg ##1 !latch_reg);
    c_break_guard: cover property (break_state && !break_clear_enable_reg && sw_ack && latch_reg);
endmodule // eipl_top
`default_nettype wire

// ---- sim/eipl_irq_source.sv ----
// Behavioural model of the external source that drives the interrupt pin.
`timescale 1ns/1ns
`default_nettype none
module eipl_irq_source (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Commands from the bench
    input  wire logic       start,
    input  wire logic       hold,
    input  wire logic [7:0] low_len,
    // Pin
    output var  logic       ext_irq_n
);
    logic [7:0] cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
        end else if (start) begin
            cnt_reg <= low_len;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    // pin driven low
    // The pin is pulled up, so a quiet source always reads high.
    assign ext_irq_n = !((cnt_reg != 8'h00) || hold);
endmodule // eipl_irq_source
`default_nettype wire

// ---- sim/eipl_top_tb.sv ----
// Self-checking bench for the external interrupt pin latch.
`timescale 1ns/1ns
`default_nettype none
module eipl_top_tb;
    // ********************************************
    // Signals and model state
    // ********************************************
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_request, ext_irq_n;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] vector_address;
    logic        vector_fetch = 1'b0, cpu_int_mask = 1'b0, break_state = 1'b0;
    logic        src_start = 1'b0, src_hold = 1'b0;
    logic [7:0]  src_len = 8'h00;
    logic [3:0]  wstrb = 4'hF;
    logic [31:0] rd, rnd;
    int          n_errors = 0, n_compared = 0;
    int          m_latch = 0, m_mode = 0, m_block = 0, k;

    always #50 aclk = ~aclk;

    eipl_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_irq_n(ext_irq_n), .vector_fetch(vector_fetch), .cpu_int_mask(cpu_int_mask),
        .break_state(break_state), .irq_request(irq_request), .vector_address(vector_address));

    eipl_irq_source src (.aclk(aclk), .aresetn(aresetn), .start(src_start), .hold(src_hold),
        .low_len(src_len), .ext_irq_n(ext_irq_n));

    // ********************************************
    // Reporting
    // ********************************************
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout();
        check("handshake", 32'h0, 32'h1);
        end_of_test();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // ********************************************
    // Bus master
    // ********************************************
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (i == 64) timeout();
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (i == 64) timeout();
    endtask

    // ********************************************
    // Model comparison
    // ********************************************
    task automatic expect_state();
        logic [31:0] exp;
        logic        irq_exp;
        exp = {28'h0, m_latch[0], 1'b0, m_block[0], m_mode[0]};
        axi_read(32'(eipl_pkg::ISC_ADDR), rd, rsp);
        check("isc", rd, exp);
        check("isc_rresp", {30'h0, rsp}, 32'h0);
        cyc(2);
        irq_exp = m_latch[0] && !m_block[0] && !cpu_int_mask;
        check("irq_request", {31'h0, irq_request}, {31'h0, irq_exp});
    endtask

    task automatic wr_isc(input int ackb);
        axi_write(32'(eipl_pkg::ISC_ADDR), 32'(ackb * 4 + m_block * 2 + m_mode), rsp);
        check("isc_wresp", {30'h0, rsp}, 32'h0);
        cyc(2);
    endtask

    task automatic pin_pulse(input int len);
        @(posedge aclk);
        src_len   <= 8'(len);
        src_start <= 1'b1;
        @(posedge aclk);
        src_start <= 1'b0;
        cyc(len + 12);
    endtask

    task automatic fetch();
        @(posedge aclk);
        vector_fetch <= 1'b1;
        @(posedge aclk);
        vector_fetch <= 1'b0;
        cyc(2);
    endtask

    initial begin
        repeat (100000) @(posedge aclk);
        timeout();
    end

    // ********************************************
    // Scenarios
    // ********************************************
    initial begin
        void'($urandom(32'h9cd748fd));
        cyc(4);
        aresetn <= 1'b1;
        cyc(2);
        expect_state();
        check("vector", {16'h0, vector_address}, 32'h0000FFFA);
        axi_read(32'(eipl_pkg::BRK_ADDR), rd, rsp);
        check("brk", rd, 32'h0);
        for (k = 0; k < 4; k++) begin
            rnd = $urandom;
            m_block = int'(rnd[1]);
            m_mode = int'(rnd[0]);
            axi_write(32'(eipl_pkg::ISC_ADDR), rnd, rsp);
            expect_state();
        end
        m_block = 0;
        m_mode = 0;
        wr_isc(0);
        axi_read(32'h40, rd, rsp);
        check("unmapped_rd", {rd[29:0], rsp}, {30'h0, eipl_pkg::RESP_SLVERR});
        axi_write(32'h44, 32'hFFFFFFFF, rsp);
        check("unmapped_wr", {30'h0, rsp}, {30'h0, eipl_pkg::RESP_SLVERR});
        expect_state();
        pin_pulse(4 + int'($urandom % 20));
        m_latch = 1;
        expect_state();
        cpu_int_mask <= 1'b1;
        expect_state();
        cpu_int_mask <= 1'b0;
        m_block = 1;
        wr_isc(0);
        expect_state();
        m_block = 0;
        wr_isc(0);
        src_len   <= 8'd80;
        src_start <= 1'b1;
        cyc(1);
        src_start <= 1'b0;
        cyc(14);
        wr_isc(1);
        m_latch = 0;
        expect_state();
        cyc(80);
        expect_state();
        pin_pulse(6);
        m_latch = 1;
        expect_state();
        fetch();
        m_latch = 0;
        expect_state();
        m_mode = 1;
        wr_isc(0);
        src_hold <= 1'b1;
        cyc(12);
        m_latch = 1;
        expect_state();
        // Handler blocks the request before acknowledging, as level mode needs.
        m_block = 1;
        wr_isc(0);
        wr_isc(1);
        expect_state();
        fetch();
        expect_state();
        src_hold <= 1'b0;
        cyc(12);
        m_latch = 0;
        expect_state();
        src_hold <= 1'b1;
        cyc(12);
        src_hold <= 1'b0;
        cyc(12);
        m_latch = 1;
        expect_state();
        fetch();
        m_latch = 0;
        expect_state();
        m_block = 0;
        m_mode = 0;
        wr_isc(0);
        pin_pulse(6);
        m_latch = 1;
        break_state <= 1'b1;
        wr_isc(1);
        expect_state();
        axi_write(32'(eipl_pkg::BRK_ADDR), 32'h1, rsp);
        axi_read(32'(eipl_pkg::BRK_ADDR), rd, rsp);
        check("brk", rd, 32'h1);
        wr_isc(1);
        m_latch = 0;
        expect_state();
        break_state <= 1'b0;
        cyc(4);
        expect_state();
        m_mode = 1;
        wr_isc(0);
        src_hold <= 1'b1;
        cyc(12);
        m_latch = 1;
        expect_state();
        aresetn <= 1'b0;
        cyc(2);
        check("irq_in_reset", {31'h0, irq_request}, 32'h0);
        src_hold <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        m_latch = 0;
        m_mode = 0;
        cyc(14);
        expect_state();
        axi_read(32'(eipl_pkg::BRK_ADDR), rd, rsp);
        check("brk", rd, 32'h0);
        end_of_test();
    end
endmodule // eipl_top_tb
`default_nettype wire
